/* include/reset_cause_map.svh */
// register offsets, field positions, reset values and timing figures of the reset cause block
`ifndef RESET_CAUSE_MAP_SVH
`define RESET_CAUSE_MAP_SVH

`define PWR_STATUS_OFS 4'h0
`define CPU_STATUS_OFS 4'h4
`define CONFIG_OFS 4'h8
`define PC_INFO_OFS 4'hc

`define BOR_BIT 0
`define POR_BIT 1
`define PD_BIT 3
`define TO_BIT 4
`define STATUS_W 8
`define STATUS_SW_MASK 8'he7
`define STATUS_HI_MASK 8'he0
`define STATUS_RST 8'h18
`define PWR_STATUS_RST 2'h0

`define CFG_BOREN_BIT 0
`define CFG_POWERUP_TIMER_ENABLE_N_N_BIT 1
`define CFG_MODE_LSB 2
`define CFG_BOREN_RST 1'b1
`define CFG_POWERUP_TIMER_ENABLE_N_N_RST 1'b0
`define CFG_MODE_RST 2'h1

`define INFO_HOLD_BIT 16
`define INFO_VALID_BIT 17
`define INFO_CAUSE_LSB 20

`define PWRT_MS 72
`define NS_PER_MS 1000000
`define CLK_PERIOD_NS 8
`define OST_PERIODS 1024

`define PC_W 13
`define RESET_VECTOR 13'h000
`define INT_VECTOR 13'h004

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* include/reset_cause_pkg.sv */
// types shared by the reset cause block
package reset_cause_pkg;
	typedef enum logic [2:0] {
		KindPor,
		KindBor,
		KindExtRun,
		KindExtSleep,
		KindWdtReset,
		KindWdtWake,
		KindIrqWake
	} reset_kind_type;

	typedef enum logic [1:0] {
		XtalLowMode,
		XtalMidMode,
		XtalHighMode,
		RcOscMode
	} osc_mode_type;

	typedef enum logic [1:0] {
		TimerIdle,
		TimerPwrt,
		TimerOst
	} timer_state_type;
endpackage : reset_cause_pkg

/* include/startup_if.sv */
// link between the reset cause logic and its start-up delay timer
`timescale 1ns/1ps
`default_nettype none
interface startup_if;
	logic start;
	logic usePwrt;
	logic useOst;
	logic busy;
	logic done;

	modport ctrl (output start, output usePwrt, output useOst, input busy, input done);
	modport timer (input start, input usePwrt, input useOst, output busy, output done);
endinterface : startup_if
`default_nettype wire

/* core/startup_delay_timer.sv */
// start-up delay timer: power-up delay in clock cycles, then oscillator period count
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_map.svh"
module startup_delay_timer #(
	parameter int PWRT_CYCLES = 9000000,
	parameter int OST_PERIODS = `OST_PERIODS,
	parameter int CNT_W = 24
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic oscTick,
	startup_if.timer tmr
);
	import reset_cause_pkg::*;

	timer_state_type state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic useOst_ff, nxt_useOst;
	logic done_ff, nxt_done;

	////////////////////////////////////////////////////////////////////////////////
	// next state: a new start always restarts the whole sequence
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_useOst = useOst_ff;
		nxt_done = 1'b0;
		if (tmr.start) begin
			nxt_useOst = tmr.useOst;
			if (tmr.usePwrt) begin
				nxt_state = TimerPwrt;
				nxt_cnt = CNT_W'(PWRT_CYCLES - 1);
			end else if (tmr.useOst) begin
				nxt_state = TimerOst;
				nxt_cnt = CNT_W'(OST_PERIODS - 1);
			end else begin
				nxt_state = TimerIdle;
				nxt_done = 1'b1;
			end
		end else begin
			unique case (state_ff)
				TimerIdle: begin
				end
				TimerPwrt: begin
					if (cnt_ff == '0) begin
						if (useOst_ff) begin
							nxt_state = TimerOst;
							nxt_cnt = CNT_W'(OST_PERIODS - 1);
						end else begin
							nxt_state = TimerIdle;
							nxt_done = 1'b1;
						end
					end else begin
						nxt_cnt = cnt_ff - 1'b1;
					end
				end
				TimerOst: begin
					if (oscTick) begin
						if (cnt_ff == '0) begin
							nxt_state = TimerIdle;
							nxt_done = 1'b1;
						end else begin
							nxt_cnt = cnt_ff - 1'b1;
						end
					end
				end
				default: begin
					nxt_state = TimerIdle;
				end
			endcase
		end
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= TimerIdle;
			cnt_ff <= '0;
			useOst_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (clkEn) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			useOst_ff <= nxt_useOst;
			done_ff <= nxt_done;
		end
	end

	assign tmr.busy = (state_ff != TimerIdle);
	assign tmr.done = done_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_no_delay_done: assert property (@(posedge clk) disable iff (rst)
		(clkEn && tmr.start && !tmr.usePwrt && !tmr.useOst) |=> done_ff)
		else $error("start with no delay did not finish at once");
	a_ost_not_early: assert property (@(posedge clk) disable iff (rst)
		(clkEn && state_ff == TimerOst && !tmr.start && (!oscTick || cnt_ff != '0))
		|=> !done_ff)
		else $error("oscillator count ended before its last period");
endmodule : startup_delay_timer
`default_nettype wire

/* core/reset_cause_and_init.sv */
// reset cause flags, start-up delay selection and program counter reset load
//
// Contract
// - power status register has at most two flag bits, variant dependent
// - bit 0 is active-low brown-out flag, cleared by each brown-out reset
// - brown-out flag is meaningless while brown-out detection is disabled
// - bit 1 is active-low power-on flag, cleared only by power-on reset
// - crystal modes: power-up or brown-out wait 72 ms plus 1024 periods; power-up skips the 72 ms while delay enable and brown-out are both off
// - after power-on, power-on flag 0, timeout and powerdown flags 1
// - flag codes for brown-out, watchdog reset and watchdog wake-up
// - run external reset keeps timeout/powerdown; sleep reset or irq wake sets/clears
// - true resets load program counter 000h, wake-ups continue at pc plus one
// - interrupt wake-up with global enable set loads vector 0004h
// - status values for power-on, watchdog reset, sleep reset, watchdog wake
// - status values for interrupt wake-up and running external reset
// - power status 0x after power-on, u0 after brown-out, else unchanged
// - three reset classes; wake-up keeps contents, marked bits depend on cause
// - a wake-up requires the waking source's interrupt flag to be set
// - brown-out enabled forces the power-up delay regardless of its enable
// - oscillator count only in crystal modes, after power-on, brown-out or wake-up
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_map.svh"
module reset_cause_and_init #(
	parameter int ADDR_W = 4,
	parameter int PWRT_CYCLES =
		(`PWRT_MS * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int OST_PERIODS = `OST_PERIODS,
	parameter int CNT_W = 24
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic porEvent,
	input wire logic borEvent,
	input wire logic extResetN,
	input wire logic watchdogTimeout,
	input wire logic wakeIrq,
	input wire logic intFlagsPending,
	input wire logic sleeping,
	input wire logic globalIntEnable,
	input wire logic oscTick,
	input wire logic [`PC_W-1:0] currentPc,
	output logic coreHold,
	output logic pcLoad,
	output logic [`PC_W-1:0] pcValue,
	output var reset_cause_pkg::reset_kind_type lastCause,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import reset_cause_pkg::*;

	startup_if tmr ();

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [1:0] pwrStatus_ff, nxt_pwrStatus;
	logic [`STATUS_W-1:0] status_ff, nxt_status;
	logic borEnable_ff, nxt_borEnable;
	logic pwrtEnN_ff, nxt_pwrtEnN;
	osc_mode_type mode_ff, nxt_mode;
	reset_kind_type cause_ff, nxt_cause;
	logic extLast_ff, nxt_extLast;
	logic holdPend_ff, nxt_holdPend;
	logic gie_ff, nxt_gie;
	logic [`PC_W-1:0] savedPc_ff, nxt_savedPc;
	logic pcLoad_ff, nxt_pcLoad;
	logic [`PC_W-1:0] pcValue_ff, nxt_pcValue;
	logic awHeld_ff, nxt_awHeld;
	logic [ADDR_W-1:0] awAddr_ff, nxt_awAddr;
	logic wHeld_ff, nxt_wHeld;
	logic [31:0] wData_ff, nxt_wData;
	logic [3:0] wStrb_ff, nxt_wStrb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;

	logic eventHit;
	reset_kind_type eventKind;
	logic doWrite;
	logic xtal;

	////////////////////////////////////////////////////////////////////////////////
	// event detection; power-on beats brown-out beats external beats watchdog beats irq
	always_comb begin
		eventHit = 1'b1;
		eventKind = KindPor;
		if (porEvent) begin
			eventKind = KindPor;
		end else if (borEvent) begin
			eventKind = KindBor;
		end else if (extLast_ff && !extResetN) begin
			eventKind = sleeping ? KindExtSleep : KindExtRun;
		end else if (watchdogTimeout) begin
			eventKind = sleeping ? KindWdtWake : KindWdtReset;
		end else if (wakeIrq && sleeping && intFlagsPending) begin
			eventKind = KindIrqWake;
		end else begin
			eventHit = 1'b0;
		end
	end

	// delay choice per reset type and oscillator mode
	assign xtal = (mode_ff != RcOscMode);
	assign tmr.start = eventHit;
	assign tmr.usePwrt = (eventKind == KindBor) ||
		(eventKind == KindPor && (!pwrtEnN_ff || borEnable_ff));
	assign tmr.useOst = xtal && (eventKind == KindPor || eventKind == KindBor ||
		eventKind == KindWdtWake || eventKind == KindIrqWake);

	////////////////////////////////////////////////////////////////////////////////
	// cause flags, config and program counter load
	always_comb begin
		nxt_pwrStatus = pwrStatus_ff;
		nxt_status = status_ff;
		nxt_borEnable = borEnable_ff;
		nxt_pwrtEnN = pwrtEnN_ff;
		nxt_mode = mode_ff;
		nxt_cause = cause_ff;
		nxt_extLast = extResetN;
		nxt_holdPend = holdPend_ff;
		nxt_gie = gie_ff;
		nxt_savedPc = savedPc_ff;
		nxt_pcLoad = 1'b0;
		nxt_pcValue = pcValue_ff;
		// software writes first, so a hardware event in the same cycle wins
		if (doWrite && wStrb_ff[0]) begin
			unique case (awAddr_ff)
				`PWR_STATUS_OFS: nxt_pwrStatus = wData_ff[1:0];
				`CPU_STATUS_OFS: nxt_status = (status_ff & ~`STATUS_SW_MASK) |
					(wData_ff[`STATUS_W-1:0] & `STATUS_SW_MASK);
				`CONFIG_OFS: begin
					nxt_borEnable = wData_ff[`CFG_BOREN_BIT];
					nxt_pwrtEnN = wData_ff[`CFG_POWERUP_TIMER_ENABLE_N_N_BIT];
					nxt_mode = osc_mode_type'(wData_ff[`CFG_MODE_LSB +: 2]);
				end
				default: begin
				end
			endcase
		end
		if (eventHit) begin
			nxt_cause = eventKind;
			nxt_holdPend = 1'b1;
			nxt_gie = globalIntEnable;
			nxt_savedPc = currentPc;
			unique case (eventKind)
				KindPor: begin
					nxt_pwrStatus[`POR_BIT] = 1'b0;
					nxt_status = (nxt_status & ~`STATUS_HI_MASK);
					nxt_status[`TO_BIT] = 1'b1;
					nxt_status[`PD_BIT] = 1'b1;
				end
				KindBor: begin
					nxt_pwrStatus[`BOR_BIT] = 1'b0;
					nxt_status = (nxt_status & ~`STATUS_HI_MASK);
					nxt_status[`TO_BIT] = 1'b1;
					nxt_status[`PD_BIT] = 1'b1;
				end
				KindExtRun: begin
					nxt_status = (nxt_status & ~`STATUS_HI_MASK);
				end
				KindExtSleep: begin
					nxt_status = (nxt_status & ~`STATUS_HI_MASK);
					nxt_status[`TO_BIT] = 1'b1;
					nxt_status[`PD_BIT] = 1'b0;
				end
				KindWdtReset: begin
					nxt_status = (nxt_status & ~`STATUS_HI_MASK);
					nxt_status[`TO_BIT] = 1'b0;
					nxt_status[`PD_BIT] = 1'b1;
				end
				KindWdtWake: begin
					nxt_status[`TO_BIT] = 1'b0;
					nxt_status[`PD_BIT] = 1'b0;
				end
				KindIrqWake: begin
					nxt_status[`TO_BIT] = 1'b1;
					nxt_status[`PD_BIT] = 1'b0;
				end
			endcase
		end else if (tmr.done && holdPend_ff) begin
			nxt_holdPend = 1'b0;
			nxt_pcLoad = 1'b1;
			if (cause_ff == KindIrqWake && gie_ff) begin
				nxt_pcValue = `INT_VECTOR;
			end else if (cause_ff == KindIrqWake || cause_ff == KindWdtWake) begin
				nxt_pcValue = savedPc_ff + 1'b1;
			end else begin
				nxt_pcValue = `RESET_VECTOR;
			end
		end
	end

	// power-on state: cause flags as after a power-on reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwrStatus_ff <= `PWR_STATUS_RST;
			status_ff <= `STATUS_RST;
			borEnable_ff <= `CFG_BOREN_RST;
			pwrtEnN_ff <= `CFG_POWERUP_TIMER_ENABLE_N_N_RST;
			mode_ff <= osc_mode_type'(`CFG_MODE_RST);
			cause_ff <= KindPor;
			extLast_ff <= 1'b1;
			holdPend_ff <= 1'b0;
			gie_ff <= 1'b0;
			savedPc_ff <= `RESET_VECTOR;
			pcLoad_ff <= 1'b0;
			pcValue_ff <= `RESET_VECTOR;
		end else if (clkEn) begin
			pwrStatus_ff <= nxt_pwrStatus;
			status_ff <= nxt_status;
			borEnable_ff <= nxt_borEnable;
			pwrtEnN_ff <= nxt_pwrtEnN;
			mode_ff <= nxt_mode;
			cause_ff <= nxt_cause;
			extLast_ff <= nxt_extLast;
			holdPend_ff <= nxt_holdPend;
			gie_ff <= nxt_gie;
			savedPc_ff <= nxt_savedPc;
			pcLoad_ff <= nxt_pcLoad;
			pcValue_ff <= nxt_pcValue;
		end
	end

	// held in reset while a delay runs or the external reset pin is low
	assign coreHold = holdPend_ff || !extResetN;
	assign pcLoad = pcLoad_ff;
	assign pcValue = pcValue_ff;
	assign lastCause = cause_ff;

	startup_delay_timer #(
		.PWRT_CYCLES(PWRT_CYCLES),
		.OST_PERIODS(OST_PERIODS),
		.CNT_W(CNT_W)
	) delayTimer (
		.clk(clk),
		.rst(rst),
		.clkEn(clkEn),
		.oscTick(oscTick),
		.tmr(tmr)
	);

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave: address and data taken in any order, one answer each
	assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;

	always_comb begin
		nxt_awHeld = awHeld_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wHeld = wHeld_ff;
		nxt_wData = wData_ff;
		nxt_wStrb = wStrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_awHeld = 1'b1;
			nxt_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_wHeld = 1'b1;
			nxt_wData = s_axi_wdata;
			nxt_wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = (awAddr_ff == `PWR_STATUS_OFS || awAddr_ff == `CPU_STATUS_OFS ||
				awAddr_ff == `CONFIG_OFS || awAddr_ff == `PC_INFO_OFS) ?
				`RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rdata = '0;
			nxt_rresp = `RESP_OKAY;
			unique case (s_axi_araddr)
				`PWR_STATUS_OFS: nxt_rdata[1:0] = pwrStatus_ff;
				`CPU_STATUS_OFS: nxt_rdata[`STATUS_W-1:0] = status_ff;
				`CONFIG_OFS: begin
					nxt_rdata[`CFG_BOREN_BIT] = borEnable_ff;
					nxt_rdata[`CFG_POWERUP_TIMER_ENABLE_N_N_BIT] = pwrtEnN_ff;
					nxt_rdata[`CFG_MODE_LSB +: 2] = mode_ff;
				end
				`PC_INFO_OFS: begin
					nxt_rdata[`PC_W-1:0] = pcValue_ff;
					nxt_rdata[`INFO_HOLD_BIT] = coreHold;
					nxt_rdata[`INFO_VALID_BIT] = borEnable_ff;
					nxt_rdata[`INFO_CAUSE_LSB +: 3] = cause_ff;
				end
				default: nxt_rresp = `RESP_SLVERR;
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	// bus registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= '0;
			wHeld_ff <= 1'b0;
			wData_ff <= '0;
			wStrb_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= `RESP_OKAY;
		end else if (clkEn) begin
			awHeld_ff <= nxt_awHeld;
			awAddr_ff <= nxt_awAddr;
			wHeld_ff <= nxt_wHeld;
			wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	assign s_axi_awready = clkEn && !awHeld_ff && !bvalid_ff;
	assign s_axi_wready = clkEn && !wHeld_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = clkEn && !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_por_flags_set: assert property (@(posedge clk) disable iff (rst)
		(clkEn && porEvent) |=> (!pwrStatus_ff[`POR_BIT] && status_ff[`TO_BIT] &&
		status_ff[`PD_BIT] && status_ff[7:5] == 3'h0))
		else $error("power-on did not give the power-on flag pattern");
	a_bor_flag_clear: assert property (@(posedge clk) disable iff (rst)
		(clkEn && borEvent && !porEvent) |=> (!pwrStatus_ff[`BOR_BIT] &&
		pwrStatus_ff[`POR_BIT] == $past(pwrStatus_ff[`POR_BIT])))
		else $error("brown-out did not clear only the brown-out flag");
	a_wdt_wake_code: assert property (@(posedge clk) disable iff (rst)
		(clkEn && eventHit && eventKind == KindWdtWake) |=>
		(status_ff[`TO_BIT] == 1'b0 && status_ff[`PD_BIT] == 1'b0 &&
		status_ff[7:5] == $past(status_ff[7:5])))
		else $error("watchdog wake-up gave a wrong status pattern");
	a_ext_run_keeps: assert property (@(posedge clk) disable iff (rst)
		(clkEn && eventHit && eventKind == KindExtRun) |=>
		(status_ff[4:0] == $past(status_ff[4:0]) && status_ff[7:5] == 3'h0 &&
		pwrStatus_ff == $past(pwrStatus_ff)))
		else $error("running external reset altered kept bits");
	a_pwrt_forced: assert property (@(posedge clk) disable iff (rst)
		(eventHit && eventKind == KindPor && borEnable_ff) |-> tmr.usePwrt)
		else $error("power-up delay skipped while brown-out is enabled");
	a_pc_reset_vec: assert property (@(posedge clk) disable iff (rst)
		(pcLoad_ff && cause_ff != KindIrqWake && cause_ff != KindWdtWake) |->
		(pcValue_ff == `RESET_VECTOR))
		else $error("true reset did not load the reset vector");
	a_pc_int_vec: assert property (@(posedge clk) disable iff (rst)
		(pcLoad_ff && cause_ff == KindIrqWake && gie_ff) |-> (pcValue_ff == `INT_VECTOR))
		else $error("interrupt wake-up with enable did not load the vector");
	a_hold_to_done: assert property (@(posedge clk) disable iff (rst)
		(clkEn && eventHit) |=> (coreHold && !pcLoad_ff))
		else $error("core released before its start-up delay");
	a_wake_has_flag: assert property (@(posedge clk) disable iff (rst)
		(clkEn && wakeIrq && sleeping && !intFlagsPending && extResetN && !porEvent &&
		!borEvent && !watchdogTimeout) |=> (cause_ff == $past(cause_ff)))
		else $error("interrupt wake-up taken without a pending flag");
endmodule : reset_cause_and_init
`default_nettype wire

/* testbench/reset_cause_and_init_tb.sv */
// self-checking bench for the reset cause and start-up block
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_init_tb;
	import reset_cause_pkg::*;
	localparam int PW = 20;
	localparam int OS = 4;
	logic clk = 1'h0, rst = 1'h1, clkEn = 1'h1, porEvent = 1'h0, borEvent = 1'h0;
	logic extResetN = 1'h1, watchdogTimeout = 1'h0, wakeIrq = 1'h0, intFlagsPending = 1'h0;
	logic sleeping = 1'h0, globalIntEnable = 1'h0, oscTick = 1'h0, coreHold, pcLoad;
	logic [12:0] currentPc = 13'h0, pcValue;
	reset_kind_type lastCause;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, pwrExp;
	logic [7:0] stExp;
	int errCount = 0, checked = 0;

	// short timer figures keep the run brief
	reset_cause_and_init #(.PWRT_CYCLES(PW), .OST_PERIODS(OS)) dut (
		.clk, .rst, .clkEn, .porEvent, .borEvent, .extResetN, .watchdogTimeout, .wakeIrq,
		.intFlagsPending, .sleeping, .globalIntEnable, .oscTick, .currentPc, .coreHold,
		.pcLoad, .pcValue, .lastCause, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// clock and an oscillator tick every other cycle
	always #4 clk = ~clk;
	always @(posedge clk) oscTick <= ~oscTick;

	////////////////////////////////////////////////////////////////////////////////
	// reporting
	task automatic fail(input string s);
		errCount++;
		$display("ERROR %0t: %s", $time, s);
	endtask : fail

	task automatic chk(input logic [31:0] g, e, m, input string s);
		checked++;
		if ((g & m) !== (e & m)) begin
			fail(s);
		end
	endtask : chk

	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", errCount, checked);
		if (errCount == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////////////
	// reset and register bus master
	task automatic do_reset;
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		pwrExp = 2'h0;
		stExp = 8'h18;
	endtask : do_reset

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'h0;
		w = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && s_axi_awready === 1'h1) begin
				aw = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w && s_axi_wready === 1'h1) begin
				w = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		// ready for the answer only once both halves are taken
		s_axi_bready <= 1'h1;
		do @(posedge clk); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk(32'(s_axi_bresp), 32'(er), 32'h3, "write response");
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e, m, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, e, m, "read data");
		chk(32'(s_axi_rresp), 32'(er), 32'h3, "read response");
	endtask : rd

	////////////////////////////////////////////////////////////////////////////////
	// one reset or wake-up event, its start-up delay and the flags it leaves
	task automatic ev(input reset_kind_type k, input logic [3:0] cfg);
		logic [12:0] pc;
		logic [12:0] pe;
		logic [31:0] d;
		logic global_int_enable;
		logic p;
		logic o;
		int n;
		int lo;
		int hi;
		pc = 13'($urandom);
		global_int_enable = 1'($urandom);
		d = $urandom;
		wr(4'h8, {28'h0, cfg}, 4'hf, 2'h0);
		wr(4'h0, 32'h3, 4'hf, 2'h0);
		wr(4'h4, d, 4'hf, 2'h0);
		pwrExp = 2'h3;
		stExp = (d[7:0] & 8'he7) | (stExp & 8'h18);
		currentPc <= pc;
		globalIntEnable <= global_int_enable;
		sleeping <= k inside {KindExtSleep, KindWdtWake, KindIrqWake};
		intFlagsPending <= (k == KindIrqWake);
		porEvent <= (k == KindPor);
		borEvent <= (k == KindBor);
		extResetN <= !(k inside {KindExtRun, KindExtSleep});
		watchdogTimeout <= k inside {KindWdtReset, KindWdtWake};
		wakeIrq <= (k == KindIrqWake);
		@(posedge clk);
		{porEvent, borEvent, watchdogTimeout, wakeIrq, sleeping, intFlagsPending} <= 6'h0;
		extResetN <= 1'h1;
		p = (k == KindBor) || (k == KindPor && (!cfg[1] || cfg[0]));
		o = (cfg[3:2] != 2'h3) && (k inside {KindPor, KindBor, KindWdtWake, KindIrqWake});
		// ticks come every other cycle, so the count lasts 2*OS-1 or 2*OS cycles
		lo = (p ? PW : 0) + (o ? 2 * OS - 1 : 0) + 2;
		hi = lo + (o ? 1 : 0);
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (pcLoad !== 1'h1) chk(32'(coreHold), 32'h1, 32'h1, "hold");
		end while (pcLoad !== 1'h1 && n < 500);
		chk(32'(n >= lo && n <= hi), 32'h1, 32'h1, "start-up delay");
		pe = 13'h0;
		if (k inside {KindWdtWake, KindIrqWake}) pe = pc + 13'h1;
		if (k == KindIrqWake && global_int_enable) pe = 13'h4;
		chk(32'(pcValue), 32'(pe), 32'h1fff, "program counter");
		chk(32'(coreHold), 32'h0, 32'h1, "release");
		chk(32'(lastCause), 32'(k), 32'h7, "last cause");
		// expected cause flags and status bits
		if (k == KindPor) pwrExp[1] = 1'h0;
		if (k == KindBor) pwrExp[0] = 1'h0;
		if (k < KindWdtWake) stExp[7:5] = 3'h0;
		case (k)
			KindPor, KindBor: stExp[4:3] = 2'h3;
			KindExtSleep, KindIrqWake: stExp[4:3] = 2'h2;
			KindWdtReset: stExp[4:3] = 2'h1;
			KindWdtWake: stExp[4:3] = 2'h0;
			default: ;
		endcase
		rd(4'h0, 32'(pwrExp), (k == KindPor) ? 32'hfffffffe : 32'hffffffff, 2'h0);
		rd(4'h4, 32'(stExp), (k == KindPor) ? 32'hfffffff8 : 32'hffffffff, 2'h0);
		rd(4'hc, {9'h0, 3'(k), 2'h0, cfg[0], 1'h0, 3'h0, pe}, 32'hffffffff, 2'h0);
	endtask : ev

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(32'hf389));
		do_reset();
		rd(4'h0, 32'h0, 32'hffffffff, 2'h0);
		rd(4'h4, 32'h18, 32'hffffffff, 2'h0);
		rd(4'h8, 32'h5, 32'hffffffff, 2'h0);
		rd(4'hc, 32'h20000, 32'hffffffff, 2'h0);
		rd(4'h2, 32'h0, 32'hffffffff, 2'h2);
		wr(4'h1, 32'h3, 4'hf, 2'h2);
		wr(4'h0, 32'h3, 4'h0, 2'h0);
		rd(4'h0, 32'h0, 32'hffffffff, 2'h0);
		wr(4'h0, 32'hffffffff, 4'hf, 2'h0);
		rd(4'h0, 32'h3, 32'hffffffff, 2'h0);
		ev(KindPor, 4'h6);
		ev(KindPor, 4'he);
		for (int r = 0; r < 3; r++) begin
			for (int i = 0; i < 7; i++) ev(reset_kind_type'(i), 4'($urandom));
		end
		// interrupt wake without a pending flag is ignored
		sleeping <= 1'h1;
		wakeIrq <= 1'h1;
		@(posedge clk);
		wakeIrq <= 1'h0;
		repeat (4) begin
			@(posedge clk);
			chk(32'(pcLoad | coreHold), 32'h0, 32'h1, "ignored wake");
		end
		sleeping <= 1'h0;
		// a power-on pulse while the clock enable is low starts nothing
		clkEn <= 1'h0;
		porEvent <= 1'h1;
		@(posedge clk);
		porEvent <= 1'h0;
		repeat (3) begin
			@(posedge clk);
			chk(32'(pcLoad | coreHold), 32'h0, 32'h1, "frozen by clock enable");
		end
		clkEn <= 1'h1;
		do_reset();
		rd(4'h0, 32'h0, 32'hffffffff, 2'h0);
		stop_test();
	end

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		fail("timeout");
		stop_test();
	end
endmodule : reset_cause_and_init_tb
`default_nettype wire
